/* File: core/sfm_monitor.sv */
// Safety fault monitor: fault collection, safe state, diagnostics, LEDs
`timescale 1ns/1ns
`include "sfm_cfg.svh"
module sfm_monitor #(
  parameter int unsigned N = `SFM_CHANNELS,
  parameter int unsigned DTI_CYC = `SFM_DTI_CYC,
  parameter int unsigned WD_MIN_CYC = `SFM_WD_MIN_CYC,
  parameter int unsigned WD_MAX_CYC = `SFM_WD_MAX_CYC,
  parameter int unsigned WD_HOLD_CYC = `SFM_WD_HOLD_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic vin_low_in,
  input wire logic vin_high_in,
  input wire logic [3:0] pd_fault_in,
  input wire logic int_rail_fault_n_in,
  input wire logic io_rail_low_in,
  input wire logic io_rail_ov_in,
  input wire logic core_uv_fault_n_in,
  input wire logic core_ov_fault_n_in,
  input wire logic overtemp_fault_n_in,
  input wire logic cpu_error_n_in,
  input wire logic watchdog_kick_in,
  input wire logic test_trip_n_in,
  input wire logic cold_block_in,
  input wire logic warm_block_in,
  input wire logic fault_led_ctl_in,
  input wire logic led_sclk_in,
  input wire logic led_sdata_in,
  input wire logic led_latch_in,
  input wire logic [N-1:0] di_state_in,
  output logic sensor_supply_fault_n_out,
  output logic sensor_power_en_out,
  output logic int_rail_fault_n_out,
  output logic io_ov_notify_out,
  output logic core_uv_flag_out,
  output logic core_ov_latched_out,
  output logic overtemp_fault_n_out,
  output logic supervisor_trip_n_out,
  output logic watchdog_fail_n_out,
  output logic cold_reset_n_out,
  output logic warm_reset_n_out,
  output logic safe_state_n_out,
  output logic [N-1:0] inject_en_out,
  output logic [N-1:0] inject_level_out,
  output logic [N-1:0] channel_led_out,
  output logic supply_led_out,
  output logic fault_led_out
);

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [`SFM_NUM_FLAGS-1:0] flag_raw;
  logic [`SFM_NUM_FLAGS-1:0] flag_s;
  logic [N-1:0] di_s;

  // Active-low pins are inverted ahead of the first stage so everything
  // resets to the no-fault level of zero
  assign flag_raw = {led_latch_in, led_sdata_in, led_sclk_in,
    fault_led_ctl_in, warm_block_in, cold_block_in, ~test_trip_n_in,
    watchdog_kick_in, ~cpu_error_n_in, ~overtemp_fault_n_in,
    ~core_ov_fault_n_in, ~core_uv_fault_n_in, io_rail_ov_in,
    io_rail_low_in, ~int_rail_fault_n_in, pd_fault_in, vin_high_in,
    vin_low_in};

  sfm_sync #(.W(`SFM_NUM_FLAGS)) u_flag_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(flag_raw),
    .q_out(flag_s)
  );

  sfm_sync #(.W(N)) u_di_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(di_state_in),
    .q_out(di_s)
  );

  wire s_vin_low = flag_s[0];
  wire s_vin_high = flag_s[1];
  wire [3:0] s_pd_fault = flag_s[5:2];
  wire s_int_rail = flag_s[6];
  wire s_io_low = flag_s[7];
  wire s_io_ov = flag_s[8];
  wire s_core_uv = flag_s[9];
  wire s_core_ov = flag_s[10];
  wire s_overtemp = flag_s[11];
  wire s_cpu_err = flag_s[12];
  wire s_kick = flag_s[13];
  wire s_test_trip = flag_s[14];
  wire s_cold_block = flag_s[15];
  wire s_warm_block = flag_s[16];
  wire s_fault_led = flag_s[17];
  wire s_led_sclk = flag_s[18];
  wire s_led_sdata = flag_s[19];
  wire s_led_latch = flag_s[20];

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  sfm_wd_if wd_bus ();
  logic kick_d_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      kick_d_r <= 1'b0;
    end else begin
      kick_d_r <= s_kick;
    end
  end

  assign wd_bus.kick_fall = kick_d_r && !s_kick;

  sfm_wdog #(
    .MIN_CYC(WD_MIN_CYC),
    .MAX_CYC(WD_MAX_CYC),
    .HOLD_CYC(WD_HOLD_CYC)
  ) u_wdog (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wd(wd_bus.wdog)
  );

  wire wd_fail = !wd_bus.fail_n;

  // ----------------------------------------
  // Fault classification
  // ----------------------------------------
  logic core_ov_latch_r;
  wire manual_trip_n = !s_test_trip;
  // supervisor trip while rail low or manual trip held
  wire sup_trip = s_io_low || !manual_trip_n;
  wire core_ov_nxt = core_ov_latch_r || s_core_ov;
  // unmaskable trigger set; I/O overvoltage deliberately absent
  wire safe_trig = s_cpu_err || wd_fail || sup_trip || s_core_uv ||
    core_ov_nxt;
  // cold block masks only the supervisor cold reboot
  // core faults always hold cold reset
  wire cold_rst = (sup_trip && !s_cold_block) || s_core_uv || core_ov_nxt;
  wire warm_rst = (wd_fail || s_cpu_err) && !s_warm_block;
  // any power delivery or supply window fault
  wire supply_bad = s_vin_low || s_vin_high || (|s_pd_fault);

  // sticky core overvoltage latch, cleared only by power-on reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      core_ov_latch_r <= 1'b0;
    end else begin
      core_ov_latch_r <= core_ov_nxt;
    end
  end

  // registered safe state, one cycle after trigger
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      safe_state_n_out <= 1'b1;
      cold_reset_n_out <= 1'b1;
      warm_reset_n_out <= 1'b1;
      supervisor_trip_n_out <= 1'b1;
      watchdog_fail_n_out <= 1'b1;
    end else begin
      safe_state_n_out <= !safe_trig;
      cold_reset_n_out <= !cold_rst;
      warm_reset_n_out <= !warm_rst;
      supervisor_trip_n_out <= !sup_trip;
      watchdog_fail_n_out <= !wd_fail;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sensor_supply_fault_n_out <= 1'b1;
      sensor_power_en_out <= 1'b0;
      int_rail_fault_n_out <= 1'b1;
      io_ov_notify_out <= 1'b0;
      core_uv_flag_out <= 1'b0;
      core_ov_latched_out <= 1'b0;
      overtemp_fault_n_out <= 1'b1;
    end else begin
      sensor_supply_fault_n_out <= !supply_bad;
      sensor_power_en_out <= !supply_bad;
      int_rail_fault_n_out <= !s_int_rail;
      io_ov_notify_out <= s_io_ov;
      core_uv_flag_out <= s_core_uv;
      core_ov_latched_out <= core_ov_nxt;
      overtemp_fault_n_out <= !s_overtemp;
    end
  end

  // ----------------------------------------
  // Input front-end injection
  // ----------------------------------------
  // one stale-time counter per channel; a toggle restarts it
  // which also ends the injection once the channel has moved
  logic [N-1:0] di_d_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      di_d_r <= '0;
    end else begin
      di_d_r <= di_s;
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_inj
    sfm_pkg::sfm_cnt_t stale_r;
    wire changed = di_s[i] ^ di_d_r[i];
    wire stale = (stale_r >= DTI_CYC[23:0]);

    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        stale_r <= '0;
        inject_en_out[i] <= 1'b0;
        inject_level_out[i] <= 1'b0;
      end else begin
        if (changed) begin
          stale_r <= '0;
        end else if (!stale) begin
          stale_r <= stale_r + 24'h000001;
        end
        inject_en_out[i] <= stale && !changed;
        inject_level_out[i] <= !di_s[i];
      end
    end
  end

  // ----------------------------------------
  // Signage
  // ----------------------------------------
  logic [N-1:0] led_shift_r;
  logic [N-1:0] led_hold_r;
  logic led_user_r;
  logic sclk_d_r;
  logic latch_d_r;
  wire sclk_rise = s_led_sclk && !sclk_d_r;
  wire latch_rise = s_led_latch && !latch_d_r;
  // channel LED follows the input until software loads a pattern
  wire [N-1:0] led_nxt = led_user_r ? led_hold_r : di_s;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sclk_d_r <= 1'b0;
      latch_d_r <= 1'b0;
      led_shift_r <= N'(`SFM_LED_RST);
      led_hold_r <= N'(`SFM_LED_RST);
      led_user_r <= 1'b0;
    end else begin
      sclk_d_r <= s_led_sclk;
      latch_d_r <= s_led_latch;
      if (sclk_rise) begin
        led_shift_r <= {led_shift_r[N-2:0], s_led_sdata};
      end
      if (latch_rise) begin
        led_hold_r <= led_shift_r;
        led_user_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      channel_led_out <= '0;
      supply_led_out <= 1'b0;
      fault_led_out <= 1'b0;
    end else begin
      channel_led_out <= led_nxt;
      supply_led_out <= !s_vin_low;
      fault_led_out <= s_fault_led;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_core_ov_seen;
    s_core_ov ##1 core_ov_latched_out;
  endsequence

  chk_core_ov_sticky: assert property (s_core_ov_seen |=>
    core_ov_latched_out [*8]) else $error("core OV latch released");
  chk_safe_trigger: assert property (safe_trig |=>
    !safe_state_n_out) else $error("safe state missed a trigger");
  chk_safe_unmasked: assert property (wd_fail && s_warm_block
    |=> !safe_state_n_out && warm_reset_n_out)
    else $error("safe state masked by warm block");
  chk_io_ov_notify: assert property (s_io_ov && !safe_trig |=>
    io_ov_notify_out && safe_state_n_out && cold_reset_n_out)
    else $error("I/O overvoltage forced reset");
  chk_cold_block: assert property (sup_trip && s_cold_block &&
    !s_core_uv && !core_ov_nxt |=> cold_reset_n_out && !safe_state_n_out)
    else $error("cold block not honoured");
  chk_core_uv_nolatch: assert property (s_core_uv && !core_ov_nxt
    |=> !core_ov_latched_out && !cold_reset_n_out)
    else $error("core UV handled wrongly");
  chk_sensor_flag: assert property ((s_vin_low || s_vin_high) |=>
    !sensor_supply_fault_n_out && !sensor_power_en_out)
    else $error("supply window fault not flagged");
  chk_supply_led: assert property (s_vin_low |=> !supply_led_out)
    else $error("supply LED lit under 19 V");
  chk_inject_stale: assert property (g_inj[0].stale &&
    !g_inj[0].changed |=> inject_en_out[0] &&
    (inject_level_out[0] != $past(di_s[0])))
    else $error("stale channel not injected");
  chk_trip_test: assert property (s_test_trip |=>
    !supervisor_trip_n_out) else $error("test trip ignored");

endmodule : sfm_monitor

/* File: pkg/sfm_cfg.svh */
// Timing constants and reset values for the safety fault monitor
`ifndef SFM_CFG_SVH
`define SFM_CFG_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define SFM_CLK_HZ 10000000
`define SFM_CYC_PER_US (`SFM_CLK_HZ / 1000000)

// ----------------------------------------
// Window watchdog
// ----------------------------------------
`define SFM_WD_MIN_US 2200
`define SFM_WD_MAX_US 9300
`define SFM_WD_HOLD_US 230000
`define SFM_WD_MIN_CYC (`SFM_WD_MIN_US * `SFM_CYC_PER_US)
`define SFM_WD_MAX_CYC (`SFM_WD_MAX_US * `SFM_CYC_PER_US)
`define SFM_WD_HOLD_CYC (`SFM_WD_HOLD_US * `SFM_CYC_PER_US)

// ----------------------------------------
// Input front-end diagnostic interval
// ----------------------------------------
`define SFM_DTI_MS 1000
`define SFM_DTI_CYC (`SFM_DTI_MS * 1000 * `SFM_CYC_PER_US)

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define SFM_CHANNELS 8
`define SFM_NUM_FLAGS 21
`define SFM_LED_RST 8'h00

`endif

/* File: pkg/sfm_pkg.sv */
// Shared types of the safety fault monitor
package sfm_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [23:0] sfm_cnt_t;

  typedef enum logic [0:0] {
    SFM_WD_RUN  = 1'b0,
    SFM_WD_FAIL = 1'b1
  } sfm_wd_state_e;

endpackage : sfm_pkg

/* File: pkg/sfm_wd_if.sv */
// Kick and fail signals between the monitor core and its watchdog
`timescale 1ns/1ns
interface sfm_wd_if;
  logic kick_fall;
  logic fail_n;
  modport ctrl (output kick_fall, input fail_n);
  modport wdog (input kick_fall, output fail_n);
endinterface : sfm_wd_if

/* File: core/sfm_sync.sv */
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
module sfm_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_r;

  // ----------------------------------------
  // Stages
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end

endmodule : sfm_sync

/* File: core/sfm_wdog.sv */
// Window watchdog: falling kick edges must arrive inside a time window
`timescale 1ns/1ns
`include "sfm_cfg.svh"
module sfm_wdog #(
  parameter int unsigned MIN_CYC = `SFM_WD_MIN_CYC,
  parameter int unsigned MAX_CYC = `SFM_WD_MAX_CYC,
  parameter int unsigned HOLD_CYC = `SFM_WD_HOLD_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  sfm_wd_if.wdog wd
);

  sfm_pkg::sfm_wd_state_e state_r;
  sfm_pkg::sfm_cnt_t cnt_r;
  wire early_kick = wd.kick_fall && (cnt_r < MIN_CYC[23:0]);
  wire late_kick = (cnt_r >= MAX_CYC[23:0]);
  wire hold_done = (cnt_r >= HOLD_CYC[23:0] - 24'h000001);

  // ----------------------------------------
  // Window check
  // ----------------------------------------
  // window check: early or missing edge trips the fail output
  // bounded fail: released after the hold time, window restarts
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= sfm_pkg::SFM_WD_RUN;
      cnt_r <= '0;
    end else begin
      unique case (state_r)
        sfm_pkg::SFM_WD_RUN: begin
          if (early_kick || late_kick) begin
            state_r <= sfm_pkg::SFM_WD_FAIL;
            cnt_r <= '0;
          end else if (wd.kick_fall) begin
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 24'h000001;
          end
        end
        sfm_pkg::SFM_WD_FAIL: begin
          if (hold_done) begin
            state_r <= sfm_pkg::SFM_WD_RUN;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 24'h000001;
          end
        end
      endcase
    end
  end

  assign wd.fail_n = (state_r == sfm_pkg::SFM_WD_RUN);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_wd_early_kick: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_r == sfm_pkg::SFM_WD_RUN) && early_kick |=> !wd.fail_n)
    else $error("early kick did not trip watchdog");
  chk_wd_late_kick: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_r == sfm_pkg::SFM_WD_RUN) && late_kick |=> !wd.fail_n)
    else $error("missing kick did not trip watchdog");
  chk_wd_hold_bound: assert property (@(posedge clk_in) disable iff (rst_in)
    !wd.fail_n |-> (cnt_r < HOLD_CYC[23:0]))
    else $error("watchdog fail held beyond limit");

endmodule : sfm_wdog

/* File: bench/sfm_cpu_model.sv */
// Processor-side model that kicks the window watchdog
`timescale 1ns/1ns
module sfm_cpu_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic kick_en_in,
  input wire logic [7:0] period_in,
  output logic watchdog_kick_out
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;

  // ------------------------------
  // Kick generator
  // ------------------------------
  assign cnt_nxt = (cnt_r == period_in - 8'h01) ? 8'h00 : cnt_r + 8'h01;

  // reference and multiplexer checks stay inside the processor
  // no pin of this block carries them, so nothing here can exercise them
  // one fall per period, none while skipped
  always_ff @(posedge clk_in) begin
    if (rst_in || !kick_en_in) begin
      cnt_r <= 8'h00;
      watchdog_kick_out <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      // Low for four clocks so the two-flop sampler cannot miss it
      watchdog_kick_out <= (cnt_r < period_in - 8'h04);
    end
  end
endmodule : sfm_cpu_model

/* File: bench/testbench.sv */
// Self-checking bench for the safety fault monitor
`timescale 1ns/1ns
module testbench;
  logic clk_in;
  logic rst_in;
  logic vin_low, vin_high, int_n, io_low, io_ov, cuv_n, cov_n, ot_n;
  logic cpu_err_n, tt_n, cold_blk, warm_blk, fled, sclk, sdata, latch;
  logic kick, kick_en, ov_seen, led_latched;
  logic [3:0] pd;
  logic [7:0] period, di, inj_en, inj_lvl, ch_led, led_exp;
  logic ssf_n, pwr_en, irf_n, io_ovn, cuv_f, cov_l, ot_o_n, sup_n;
  logic wdf_n, cold_n, warm_n, safe_n, sled, fled_o;
  int error_cnt;
  int total_checks;
  int n;

  // Short counts keep the run brief; expectations derive from these
  sfm_monitor #(.N(8), .DTI_CYC(50), .WD_MIN_CYC(20), .WD_MAX_CYC(60),
    .WD_HOLD_CYC(30)) DUT (
    .clk_in(clk_in), .rst_in(rst_in), .vin_low_in(vin_low),
    .vin_high_in(vin_high), .pd_fault_in(pd), .int_rail_fault_n_in(int_n),
    .io_rail_low_in(io_low), .io_rail_ov_in(io_ov),
    .core_uv_fault_n_in(cuv_n), .core_ov_fault_n_in(cov_n),
    .overtemp_fault_n_in(ot_n), .cpu_error_n_in(cpu_err_n),
    .watchdog_kick_in(kick), .test_trip_n_in(tt_n),
    .cold_block_in(cold_blk), .warm_block_in(warm_blk),
    .fault_led_ctl_in(fled), .led_sclk_in(sclk), .led_sdata_in(sdata),
    .led_latch_in(latch), .di_state_in(di),
    .sensor_supply_fault_n_out(ssf_n), .sensor_power_en_out(pwr_en),
    .int_rail_fault_n_out(irf_n), .io_ov_notify_out(io_ovn),
    .core_uv_flag_out(cuv_f), .core_ov_latched_out(cov_l),
    .overtemp_fault_n_out(ot_o_n), .supervisor_trip_n_out(sup_n),
    .watchdog_fail_n_out(wdf_n), .cold_reset_n_out(cold_n),
    .warm_reset_n_out(warm_n), .safe_state_n_out(safe_n),
    .inject_en_out(inj_en), .inject_level_out(inj_lvl),
    .channel_led_out(ch_led), .supply_led_out(sled),
    .fault_led_out(fled_o));

  sfm_cpu_model cpu (.clk_in(clk_in), .rst_in(rst_in),
    .kick_en_in(kick_en), .period_in(period), .watchdog_kick_out(kick));

  always #50 clk_in = ~clk_in;

  // ------------------------------
  // Compare and verdict
  // ------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // ------------------------------
  // Stimulus helpers
  // ------------------------------
  task automatic settle(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask : settle

  task automatic clean();
    @(posedge clk_in);
    {vin_low, vin_high, io_low, io_ov, cold_blk, warm_blk, fled} <= 7'h00;
    {int_n, cuv_n, cov_n, ot_n, cpu_err_n, tt_n} <= 6'h3f;
    pd <= 4'h0;
  endtask : clean

  task automatic do_reset(input logic [7:0] per);
    @(posedge clk_in);
    rst_in <= 1'b1;
    period <= per;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    ov_seen = 1'b0;
    led_latched = 1'b0;
  endtask : do_reset

  // Waits for the watchdog fail output to reach a level, bounded
  task automatic wait_wd(input logic lvl, input int lim);
    n = 0;
    while (wdf_n !== lvl && n < lim) begin
      settle(1);
      n++;
    end
  endtask : wait_wd

  // Behavioural model of every flag output, then compared
  task automatic compare_all();
    logic sf, trip, cold, warm;
    if (!cov_n) ov_seen = 1'b1;
    sf = vin_low | vin_high | (|pd);
    trip = io_low | !tt_n;
    cold = (trip & !cold_blk) | !cuv_n | ov_seen;
    warm = !cpu_err_n & !warm_blk;
    check(ssf_n, !sf);
    check(pwr_en, !sf);
    check(irf_n, int_n);
    check(io_ovn, io_ov);
    check(cuv_f, !cuv_n);
    check(cov_l, ov_seen);
    check(ot_o_n, ot_n);
    check(sup_n, !trip);
    check(wdf_n, 1'b1);
    check(cold_n, !cold);
    check(warm_n, !warm);
    check(safe_n, !(trip | cold | !cpu_err_n));
    check(sled, !vin_low);
    check(fled_o, fled);
    check(ch_led, led_latched ? led_exp : di);
  endtask : compare_all

  task automatic send_led(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk_in);
      sdata <= v[i];
      sclk <= 1'b0;
      repeat (3) @(posedge clk_in);
      sclk <= 1'b1;
      repeat (3) @(posedge clk_in);
    end
    latch <= 1'b1;
    repeat (3) @(posedge clk_in);
    latch <= 1'b0;
    led_exp = v;
    led_latched = 1'b1;
  endtask : send_led

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    logic [31:0] r;
    clk_in = 1'b0;
    rst_in = 1'b1;
    error_cnt = 0;
    total_checks = 0;
    {vin_low, vin_high, io_low, io_ov, cold_blk, warm_blk, fled} = 7'h00;
    {int_n, cuv_n, cov_n, ot_n, cpu_err_n, tt_n} = 6'h3f;
    {sclk, sdata, latch, ov_seen, led_latched} = 5'h00;
    pd = 4'h0;
    di = 8'h00;
    led_exp = 8'h00;
    kick_en = 1'b1;
    period = 8'h28;
    void'($urandom(76123));
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    settle(4);
    repeat (40) begin
      r = $urandom;
      @(posedge clk_in);
      {vin_low, vin_high, io_low, io_ov, cold_blk, warm_blk, fled} <= r[6:0];
      {int_n, cuv_n, ot_n, cpu_err_n, tt_n} <= r[11:7];
      pd <= r[15:12] & r[19:16];
      di <= r[27:20];
      settle(6);
      compare_all();
    end
    clean();
    cov_n <= 1'b0;
    settle(5);
    compare_all();
    @(posedge clk_in);
    cov_n <= 1'b1;
    settle(6);
    compare_all();
    // Power cycle is the only way out of passivation
    do_reset(8'h28);
    clean();
    settle(6);
    compare_all();
    // constant channels get the opposite level injected
    @(posedge clk_in);
    di <= 8'ha5;
    n = 0;
    while (inj_en !== 8'hff && n < 100) begin
      settle(1);
      n++;
    end
    check(inj_en, 8'hff);
    check(inj_lvl, 8'h5a);
    check(safe_n, 1'b1);
    @(posedge clk_in);
    di <= 8'h5a;
    settle(5);
    check(inj_en, 8'h00);
    // serial port loads the channel lamps
    send_led(8'($urandom));
    settle(4);
    compare_all();
    // skipped kicks with warm block held
    @(posedge clk_in);
    warm_blk <= 1'b1;
    kick_en <= 1'b0;
    wait_wd(1'b0, 150);
    settle(3);
    check(wdf_n, 1'b0);
    check(safe_n, 1'b0);
    check(warm_n, 1'b1);
    wait_wd(1'b1, 300);
    // Fail stands exactly the hold count of 30; three already waited
    check(8'(n), 8'h1b);
    // kicks too close together fail the watchdog
    @(posedge clk_in);
    warm_blk <= 1'b0;
    kick_en <= 1'b1;
    do_reset(8'h0a);
    wait_wd(1'b0, 100);
    settle(3);
    check(wdf_n, 1'b0);
    check(warm_n, 1'b0);
    wrap_up();
  end

  // Cuts a hang short well after the sequence should have ended
  initial begin
    #1000000;
    error_cnt++;
    wrap_up();
  end
endmodule : testbench
